/* File: logic/rcadc_pkg.sv */
package rcadc_pkg;

  // Register map on the 8-bit processor I/O port
  localparam logic [7:0] ADDR_DAC_HI = 8'hC0;
  localparam logic [7:0] ADDR_DAC_LSB0 = 8'hDE;
  localparam logic [7:0] ADDR_DAC_LSB1 = 8'hDF;
  localparam logic [7:0] ADDR_CTRL = 8'hA0;
  localparam logic [7:0] ADDR_STATUS = 8'hA1;
  localparam logic [7:0] ADDR_RES_BASE = 8'hB0;

  // Field positions
  localparam int CTRL_START_BIT = 0;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_DONE_BIT = 1;
  localparam int STAT_PF_BIT = 2;

  // Converter geometry
  localparam int CODE_W = 10;
  localparam int DAC_W = 8;
  localparam int NUM_CH = 7;
  localparam logic [9:0] CODE_ZERO = 10'h000;
  localparam logic [9:0] CODE_MAX = 10'h3FF;
  localparam logic [9:0] CODE_STEP = 10'h001;
  localparam logic [7:0] RDATA_NONE = 8'h00;

  // Settling wait after each threshold step
  localparam int CLK_PERIOD_NS = 10;
  localparam int SETTLE_NS = 1000;
  localparam int SETTLE_CYC = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 16;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_SETTLE,
    ST_SAMPLE
  } rcadc_state_t;

  // One synchronised snapshot of the comparator port
  typedef struct packed {
    logic pf;
    logic [6:0] ch;
  } rcadc_cmp_t;

endpackage

/* File: logic/rcadc_seq.sv */
// Chosen here: the strobed register port and the register offsets.
`timescale 1ns/1ps
// Overview of operation
// [RULE1] Code bits 9..2 drive the 8-bit DAC, bits 1..0 the two adder lines.
// [RULE2] Codes 0 to 1023 map monotonically from lowest to highest output.
// [RULE3] Comparator channel 7 monitors power fail; only seven channels convert.
// [RULE4] A comparator reads 0 below threshold and 1 above it.
// [RULE5] The threshold is the DAC output, rising with each code step.
// [RULE6] A conversion steps the code upward, sampling every channel each step.
// [RULE7] One sweep yields a 10-bit result for each of seven channels.
// [RULE8] An 8-bit write to address C0 loads the upper DAC code bits.
// [RULE9] Reset clears the DAC data so the threshold starts at zero.
// [RULE10] Wait a settling time per step; keep highest code still reading 0.
module rcadc_seq #(
  parameter int NCH = rcadc_pkg::NUM_CH,
  parameter int SETTLE_CYC = rcadc_pkg::SETTLE_CYC
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [6:0] i_comparator_inputs,
  input wire logic i_power_fail_comparator,
  output logic [7:0] o_rdata,
  output logic [7:0] o_analog_out,
  output logic o_dac_lsb0,
  output logic o_dac_lsb1,
  output logic o_busy
);

  rcadc_pkg::rcadc_state_t st_q, st_d;
  logic [9:0] code_q, code_d;
  logic [rcadc_pkg::CNT_W-1:0] cnt_q, cnt_d;
  logic done_q, done_d;
  logic busy_q, busy_d;
  logic [7:0] rdata_q, rdata_d;
  logic [9:0] res_q [NCH];
  logic [9:0] res_d [NCH];
  logic [7:0] cmp_raw;
  rcadc_pkg::rcadc_cmp_t cmp;
  logic start;
  logic idle;
  logic sampling;
  logic [7:0] res_idx;

  // Comparators are unclocked analog outputs, so resynchronise them
  rcadc_sync #(
    .W(8)
  ) u_sync (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_async({i_power_fail_comparator, i_comparator_inputs}),
    .o_sync(cmp_raw)
  );

  assign cmp = rcadc_pkg::rcadc_cmp_t'(cmp_raw);
  assign idle = (st_q == rcadc_pkg::ST_IDLE);
  assign sampling = (st_q == rcadc_pkg::ST_SAMPLE);
  assign start = idle && i_wr && (i_addr == rcadc_pkg::ADDR_CTRL) &&
                 i_wdata[rcadc_pkg::CTRL_START_BIT];
  assign res_idx = i_addr - rcadc_pkg::ADDR_RES_BASE;

  // Sequencer and DAC code; software writes are ignored during a sweep
  always_comb begin
    st_d = st_q;
    code_d = code_q;
    cnt_d = cnt_q;
    done_d = done_q;
    case (st_q)
      rcadc_pkg::ST_IDLE: begin
        if (start) begin
          code_d = rcadc_pkg::CODE_ZERO; // RULE6
          cnt_d = '0;
          done_d = 1'b0;
          st_d = rcadc_pkg::ST_SETTLE;
        end else if (i_wr) begin
          if (i_addr == rcadc_pkg::ADDR_DAC_HI) begin
            code_d[9:2] = i_wdata; // RULE8
          end else if (i_addr == rcadc_pkg::ADDR_DAC_LSB0) begin
            code_d[0] = i_wdata[0]; // RULE1
          end else if (i_addr == rcadc_pkg::ADDR_DAC_LSB1) begin
            code_d[1] = i_wdata[0]; // RULE1
          end
        end
      end
      rcadc_pkg::ST_SETTLE: begin
        // Threshold holds still while the DAC and comparators settle
        if (cnt_q == rcadc_pkg::CNT_W'(SETTLE_CYC - 1)) begin
          st_d = rcadc_pkg::ST_SAMPLE; // RULE10
        end else begin
          cnt_d = cnt_q + 16'h0001;
        end
      end
      rcadc_pkg::ST_SAMPLE: begin
        if (code_q == rcadc_pkg::CODE_MAX) begin
          // Park the threshold low again once the sweep is over
          code_d = rcadc_pkg::CODE_ZERO; // RULE7
          done_d = 1'b1;
          st_d = rcadc_pkg::ST_IDLE;
        end else begin
          code_d = code_q + rcadc_pkg::CODE_STEP; // RULE2 RULE5 RULE6
          cnt_d = '0;
          st_d = rcadc_pkg::ST_SETTLE;
        end
      end
      default: begin
        st_d = rcadc_pkg::ST_IDLE;
      end
    endcase
    // Busy is registered so the pin never carries decode glitches
    busy_d = (st_d != rcadc_pkg::ST_IDLE);
  end

  // Reset clears the code, so the threshold starts at its lowest
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      st_q <= rcadc_pkg::ST_IDLE;
      code_q <= rcadc_pkg::CODE_ZERO; // RULE9
      cnt_q <= '0;
      done_q <= 1'b0;
      busy_q <= 1'b0;
    end else begin
      st_q <= st_d;
      code_q <= code_d;
      cnt_q <= cnt_d;
      done_q <= done_d;
      busy_q <= busy_d;
    end
  end

  // Per-channel result: last code whose comparator still read low
  for (genvar g = 0; g < NCH; g++) begin : g_ch
    always_comb begin
      res_d[g] = res_q[g];
      if (start) begin
        res_d[g] = rcadc_pkg::CODE_ZERO;
      end else if (sampling && !cmp.ch[g]) begin
        res_d[g] = code_q; // RULE4 RULE7 RULE10
      end
    end

    always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
        res_q[g] <= rcadc_pkg::CODE_ZERO;
      end else begin
        res_q[g] <= res_d[g];
      end
    end
  end

  // Read port; the power-fail channel only shows up as a status bit
  always_comb begin
    rdata_d = rcadc_pkg::RDATA_NONE;
    if (i_rd) begin
      if (i_addr == rcadc_pkg::ADDR_STATUS) begin
        rdata_d[rcadc_pkg::STAT_BUSY_BIT] = !idle;
        rdata_d[rcadc_pkg::STAT_DONE_BIT] = done_q;
        rdata_d[rcadc_pkg::STAT_PF_BIT] = cmp.pf; // RULE3
      end else if (i_addr == rcadc_pkg::ADDR_DAC_HI) begin
        rdata_d = code_q[9:2];
      end else if (i_addr == rcadc_pkg::ADDR_DAC_LSB0) begin
        rdata_d[0] = code_q[0];
      end else if (i_addr == rcadc_pkg::ADDR_DAC_LSB1) begin
        rdata_d[0] = code_q[1];
      end else if (i_addr >= rcadc_pkg::ADDR_RES_BASE &&
                   res_idx < 8'(2 * NCH)) begin
        if (res_idx[0]) begin
          rdata_d = {6'h00, res_q[res_idx[3:1]][9:8]};
        end else begin
          rdata_d = res_q[res_idx[3:1]][7:0];
        end
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      rdata_q <= rcadc_pkg::RDATA_NONE;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // Outputs are slices of the code flop plus the read-data and busy flops
  assign o_analog_out = code_q[9:2]; // RULE1
  assign o_dac_lsb1 = code_q[1];
  assign o_dac_lsb0 = code_q[0];
  assign o_rdata = rdata_q;
  assign o_busy = busy_q;

  // Checks
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);

  a_dac_hi_write: assert property ( // RULE8
    idle && !start && i_wr && i_addr == rcadc_pkg::ADDR_DAC_HI
    |=> o_analog_out == $past(i_wdata))
    else $error("upper DAC bits not loaded by write");

  a_lsb1_write: assert property ( // RULE1
    idle && i_wr && i_addr == rcadc_pkg::ADDR_DAC_LSB1
    |=> o_dac_lsb1 == $past(i_wdata[0]) && $stable(o_analog_out))
    else $error("lsb1 line wrong after write");

  a_reset_zero: assert property (disable iff (1'b0) // RULE9
    !i_rst_n |=> code_q == rcadc_pkg::CODE_ZERO)
    else $error("DAC code not cleared by reset");

  a_ramp_step: assert property ( // RULE2
    sampling && code_q != rcadc_pkg::CODE_MAX
    |=> code_q == $past(code_q) + rcadc_pkg::CODE_STEP)
    else $error("ramp did not step up by one");

  a_settle_hold: assert property ( // RULE5
    st_q == rcadc_pkg::ST_SETTLE |=> $stable(code_q))
    else $error("threshold moved while settling");

  a_settle_len: assert property ( // RULE10
    sampling |-> $past(st_q) == rcadc_pkg::ST_SETTLE &&
    $past(cnt_q) == rcadc_pkg::CNT_W'(SETTLE_CYC - 1))
    else $error("sample taken before settling time");

  a_result_low: assert property ( // RULE4
    sampling && !cmp.ch[0] |=> res_q[0] == $past(code_q))
    else $error("result not taken on low comparator");

  a_result_high: assert property ( // RULE6
    sampling && cmp.ch[NCH-1] |=> $stable(res_q[NCH-1]))
    else $error("result changed on high comparator");

  a_sweep_end: assert property ( // RULE7
    sampling && code_q == rcadc_pkg::CODE_MAX
    |=> idle && done_q && code_q == rcadc_pkg::CODE_ZERO)
    else $error("sweep did not finish cleanly");

  c_sweep_start: cover property (start);
  c_sweep_done: cover property (sampling && code_q == rcadc_pkg::CODE_MAX);
  c_result_read: cover property (i_rd && i_addr == rcadc_pkg::ADDR_RES_BASE);

endmodule

/* File: logic/rcadc_sync.sv */
`timescale 1ns/1ps
// Two-stage synchroniser for the asynchronous comparator outputs
module rcadc_sync #(
  parameter int W = 8
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);

  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  // First stage feeds only the second stage
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= i_async;
      sync_q <= meta_q;
    end
  end

  assign o_sync = sync_q;

endmodule

/* File: testbench/rcadc_cmp_model.sv */
`timescale 1ns/1ps
// Conditioning outputs meeting the comparator port; levels are in code units
module rcadc_cmp_model (
  input wire logic [7:0] i_analog_out,
  input wire logic i_dac_lsb1,
  input wire logic i_dac_lsb0,
  input wire logic [76:0] i_levels,
  output logic [6:0] o_comparator_inputs
);
  logic [10:0] thr;
  // Threshold is the whole 10-bit code, so it climbs with every step
  assign thr = {1'b0, i_analog_out, i_dac_lsb1, i_dac_lsb0};
  // High only while a level sits strictly above the threshold
  always_comb begin
    for (int n = 0; n < 7; n++) begin
      o_comparator_inputs[n] = i_levels[n*11 +: 11] > thr;
    end
  end
endmodule

/* File: testbench/tb_ramp_compare_adc_sequencer.sv */
`timescale 1ns/1ps
module tb_ramp_compare_adc_sequencer;
  logic i_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic [7:0] i_addr = 8'h00;
  logic [7:0] i_wdata = 8'h00;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic i_pf = 1'b1;
  logic [6:0] cmp;
  logic [7:0] rdata;
  logic [7:0] dac;
  logic lsb0, lsb1, busy, pbusy;
  logic [76:0] levels;
  logic [9:0] code;
  logic [9:0] prev;
  logic [7:0] rv;
  int n_fail = 0;
  int cmp_count = 0;
  int steps = 0;
  // Levels on both sides of full scale; above 3FF never reads low
  assign levels = {11'h400, 11'h001, 11'h200, 11'h7FF, 11'h400, 11'h3FF,
                   11'h000};
  assign code = {dac, lsb1, lsb0};
  always #5 i_clk = ~i_clk;

  rcadc_seq #(.SETTLE_CYC(2)) u_dut (.i_clk(i_clk), .i_rst_n(i_rst_n),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
    .i_comparator_inputs(cmp), .i_power_fail_comparator(i_pf),
    .o_rdata(rdata), .o_analog_out(dac), .o_dac_lsb0(lsb0),
    .o_dac_lsb1(lsb1), .o_busy(busy));
  rcadc_cmp_model u_cmp (.i_analog_out(dac), .i_dac_lsb1(lsb1),
    .i_dac_lsb0(lsb0), .i_levels(levels), .o_comparator_inputs(cmp));

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
    #1;
  endtask

  // Read data is only looked at in the cycle after the strobe
  task automatic rd(input logic [7:0] a);
    @(posedge i_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1;
    rv = rdata;
  endtask

  // Code must climb by exactly one between samples while a sweep runs;
  // watched on the falling edge so the outputs have settled
  always @(negedge i_clk) begin
    if (busy && pbusy && code !== prev) begin
      check(code, prev + 10'h001);
      steps++;
    end
    prev <= code;
    pbusy <= busy;
  end

  task automatic t_reset;
    check(code, 10'h000);
    check(busy, 1'b0);
    rd(8'hC0);
    check(rv, 8'h00);
    $display("test reset done");
  endtask

  task automatic t_dac;
    wr(8'hC0, 8'hA5);
    check(dac, 8'hA5);
    wr(8'hDE, 8'h01);
    wr(8'hDF, 8'h00);
    check({lsb1, lsb0}, 2'h1);
    rd(8'hC0);
    check(rv, 8'hA5);
    // Read data stand for one cycle only, then fall back to zero
    @(posedge i_clk);
    #1;
    check(rdata, 8'h00);
    rd(8'hDE);
    check(rv, 8'h01);
    rd(8'h77);
    check(rv, 8'h00);
    rd(8'hA1);
    check(rv, 8'h04);
    $display("test dac done");
  endtask

  task automatic t_sweep;
    logic [9:0] exp;
    wr(8'hA0, 8'h01);
    check(busy, 1'b1);
    check(dac, 8'h00);
    wr(8'hC0, 8'h3C);
    check(dac, 8'h00);
    // A second start mid-sweep must not restart the ramp
    wr(8'hA0, 8'h01);
    check(dac, 8'h00);
    rd(8'hA1);
    check(rv, 8'h05);
    for (int i = 0; i < 4000 && busy !== 1'b0; i++) begin
      @(posedge i_clk);
    end
    #1;
    check(busy, 1'b0);
    check(steps, 16'h03FF);
    rd(8'hA1);
    check(rv, 8'h06);
    // Results sit in byte pairs, low byte first
    for (int n = 0; n < 7; n++) begin
      exp = (levels[n*11 +: 11] <= 11'h3FF) ? 10'h3FF : 10'h000;
      rd(8'hB0 + 8'(2 * n));
      check(rv, exp[7:0]);
      rd(8'hB1 + 8'(2 * n));
      check(rv, {6'h00, exp[9:8]});
    end
    @(posedge i_clk);
    i_pf <= 1'b0;
    repeat (3) @(posedge i_clk);
    rd(8'hA1);
    check(rv, 8'h02);
    $display("test sweep done");
  endtask

  task automatic conclude;
    $display("checks %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (8) @(posedge i_clk);
    i_rst_n <= 1'b1;
    @(posedge i_clk);
    #1;
    t_reset;
    t_dac;
    t_sweep;
    conclude;
  end

  // A sweep takes about 3100 cycles; this limit leaves ample margin
  initial begin
    #100000;
    n_fail++;
    conclude;
  end
endmodule
